// [bench/fpsc_pipe_model.sv]
`timescale 1ns/1ps
module fpsc_pipe_model
  import fpsc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       go,
  input  wire fpsc_exec_t req,
  output fpsc_exec_t      exec_in
);
  fpsc_exec_t idle_v;

  // Idle fields keep toggling so a block that ignores valid is caught
  always_comb begin
    idle_v       = ~exec_in;
    idle_v.valid = 1'b0;
  end

  // One instruction per request, one cycle wide
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      exec_in <= '0;
    end else begin
      exec_in <= go ? req : idle_v;
    end
  end
endmodule : fpsc_pipe_model

// [bench/tb_fpsc_top.sv]
`timescale 1ns/1ps
module tb_fpsc_top import fpsc_pkg::*;;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        hreadyout;
  logic        hresp;
  logic        const_rd = 1'b0;
  logic        const_sel = 1'b0;
  logic        go = 1'b0;
  logic [63:0] const_sig;
  logic [16:0] const_exp;
  fpsc_exec_t  exec_in;
  fpsc_exec_t  req = '0;
  fpsc_resp_t  resp_out;
  fpsc_resp_t  r;
  logic [63:0] v;
  int          miscompares = 0;
  int          num_checks = 0;
  localparam logic [12:0] PC3 = 13'h000c;

  always #2.5 clk = ~clk;
  assign hready = hreadyout;

  fpsc_top dut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .exec_in(exec_in), .const_rd(const_rd),
    .const_sel(const_sel), .resp_out(resp_out), .const_sig(const_sig), .const_exp(const_exp));

  fpsc_pipe_model pm (.clk(clk), .sys_rst(sys_rst), .go(go), .req(req), .exec_in(exec_in));

  task automatic test_done;
    if (miscompares == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [81:0] g, input logic [81:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // Bounded wait for the slave; a hang ends the run
  task automatic wrdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      miscompares++;
      test_done();
    end
  endtask : wrdy

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    wrdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wrdy();
    rd = hrdata;
  endtask : ahb

  task automatic w64(input logic [63:0] x);
    logic [31:0] d;
    ahb(1'b1, 32'h0, x[31:0], d);
    ahb(1'b1, 32'h4, x[63:32], d);
  endtask : w64

  task automatic r64(output logic [63:0] x);
    ahb(1'b0, 32'h0, 32'h0, x[31:0]);
    ahb(1'b0, 32'h4, 32'h0, x[63:32]);
  endtask : r64

  // f holds tiny, unorm_op, nan_op, pz_inf, spec_fail
  task automatic ex(input logic [1:0] sf, input int c, input logic [5:0] e,
                    input logic [4:0] f, input logic [81:0] res);
    int n;
    req <= {1'b1, sf, fpsc_cmpl_t'(c), e, f, res};
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (resp_out.valid !== 1'b1 && n < 20);
    if (resp_out.valid !== 1'b1) begin
      miscompares++;
      test_done();
    end
    r = resp_out;
  endtask : ex

  function automatic logic [12:0] mdl(input int c, input logic [1:0] p, input logic w);
    logic [6:0] pr;
    pr = (p == 2'h0) ? PREC_SGL : (p == 2'h2) ? PREC_DBL : PREC_EXT;
    case (c)
      1: return {PREC_SGL, w ? EXPW_REG : EXPW_SGL, 1'b0};
      2: return {PREC_DBL, w ? EXPW_REG : EXPW_DBL, 1'b0};
      3: return {PREC_SGL, EXPW_SGL, 1'b0};
      4: return {PREC_EXT, EXPW_REG, 1'b0};
      default: return (p == 2'h1) ? 13'h0001 : {pr, w ? EXPW_REG : EXPW_STK, 1'b0};
    endcase
  endfunction : mdl

  task automatic t_regs;
    logic [31:0] d;
    r64(v);
    chk(82'(v), 82'({6'h0, RST_SET, RST_SET, RST_SET, RST_SET, RST_TRAPS}));
    w64('1);
    r64(v);
    chk(82'(v), 82'(64'h03ff_ffff_ffff_efff));
    ahb(1'b0, 32'h10, 32'h0, d);
    chk(82'(d), 82'(0));
    chk(82'(hresp), 82'(0));
  endtask : t_regs

  task automatic t_traps;
    w64({6'h0, PC3, PC3, 13'h004c, PC3, 6'h00});
    for (int k = 0; k < 6; k++) begin
      ex(2'h0, 0, 6'(1 << k), (k == 1) ? 5'b01000 : 5'b0, 82'h0);
      chk(82'({r.fault, r.cause}), 82'({1'b1, 6'(1 << k)}));
    end
    ex(2'h1, 0, 6'h3f, 5'b01000, 82'h0);
    chk(82'(r.fault), 82'(0));
    ex(2'h2, 0, 6'h3f, 5'b01000, 82'h0);
    chk(82'({r.fault, r.cause}), 82'({1'b1, 6'h3f}));
    r64(v);
    chk(82'({v[31:26], v[57:52]}), 82'(12'hfc0));
    ahb(1'b0, 32'h8, 32'h0, v[31:0]);
    chk(82'(v[31:0]), 82'(6'h3f));
  endtask : t_traps

  task automatic t_soft;
    w64({6'h0, PC3, PC3, PC3, 13'h1f8c, 6'h00});
    ex(2'h0, 0, 6'h00, 5'b0, 82'h0);
    chk(82'(r.fault), 82'(0));
    ex(2'h3, 0, 6'h00, 5'b01100, 82'h0);
    chk(82'(r.fault), 82'(0));
    r64(v);
    chk(82'({v[18:13], v[53]}), 82'(7'h7e));
    ex(2'h3, 0, 6'h00, 5'b01000, 82'h0);
    chk(82'({r.fault, r.cause}), 82'({1'b1, 6'h02}));
  endtask : t_soft

  task automatic t_round;
    w64({6'h0, 13'h003c, 13'h002c, 13'h001c, PC3, 6'h3f});
    for (int s = 0; s < 4; s++) begin
      ex(2'(s), 0, 6'h20, 5'b0, 82'h0);
      chk(82'(r.rc), 82'(s));
    end
  endtask : t_round

  task automatic t_model;
    for (int m = 0; m < 8; m++) begin
      w64({6'h0, PC3, PC3, PC3, 13'(m << 1), 6'h3f});
      for (int c = 0; c < 5; c++) begin
        ex(2'h0, c, 6'h00, 5'b0, 82'h0);
        chk(82'({r.prec, r.expw, r.rsvd}), 82'(mdl(c, 2'(m >> 1), m[0])));
      end
    end
  endtask : t_model

  task automatic t_flush;
    w64({6'h0, PC3, PC3, PC3, 13'h000d, 6'h3f});
    ex(2'h0, 0, 6'h30, 5'b10000, {1'b1, 17'h00001, 64'h4000_0000_0000_0000});
    chk({r.sign, r.exp, r.sig}, {1'b1, EXP_ZERO, SIG_ZERO});
    r64(v);
    chk(82'({r.fault, v[18:17]}), 82'(3'b011));
    w64({6'h0, PC3, PC3, PC3, 13'h000d, 6'h1f});
    ex(2'h0, 0, 6'h30, 5'b10000, {1'b1, 17'h00001, 64'h4000_0000_0000_0000});
    chk(82'({r.fault, r.cause}), 82'({1'b1, 6'h20}));
    w64({6'h0, PC3, PC3, PC3, 13'h000d, 6'h2f});
    ex(2'h0, 0, 6'h30, 5'b10000, {1'b1, 17'h00001, 64'h4000_0000_0000_0000});
    chk(82'({r.fault, r.cause}), 82'({1'b1, 6'h10}));
  endtask : t_flush

  task automatic row(input logic [5:0] e, input logic [4:0] f, input logic [81:0] res,
                     input logic [81:0] want);
    ex(2'h0, 0, e, f, res);
    chk({r.sign, r.exp, r.sig}, want);
    chk(82'(r.fault), 82'(0));
  endtask : row

  // Traps all enabled here, so any stray fault shows
  task automatic t_enc;
    w64({6'h0, PC3, PC3, PC3, PC3, 6'h00});
    row(6'h00, 5'b00001, {1'b1, EXP_ONE, SIG_ONE}, {1'b0, EXP_NOT_A_THING_VALUE, SIG_ZERO});
    row(6'h00, 5'b0, {1'b0, 17'h00005, SIG_ZERO}, {1'b0, EXP_ZERO, SIG_ZERO});
    row(6'h00, 5'b0, {1'b1, EXP_MAX, 64'h1}, {1'b1, EXP_MAX, 64'h8000_0000_0000_0001});
    row(6'h00, 5'b0, {1'b0, EXP_ZERO, SIG_ONE}, {1'b0, EXP_DE_MIN, SIG_ONE});
    row(6'h00, 5'b0, {1'b0, EXP_DE_MIN, 64'h1}, {1'b0, EXP_ZERO, 64'h1});
    row(6'h01, 5'b00010, {1'b1, EXP_MAX, SIG_ONE}, {1'b1, EXP_MAX, SIG_ONE});
  endtask : t_enc

  task automatic t_const;
    for (int s = 0; s < 2; s++) begin
      const_sel <= s[0];
      const_rd <= 1'b1;
      @(posedge clk);
      const_rd <= 1'b0;
      @(posedge clk);
      chk(82'({const_exp, const_sig}), 82'(s ? {EXP_ONE, SIG_ONE} : {EXP_ZERO, SIG_ZERO}));
    end
  endtask : t_const

  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_traps();
    t_soft();
    t_round();
    t_model();
    t_flush();
    t_enc();
    t_const();
    test_done();
  end
endmodule : tb_fpsc_top

// [core/fpsc_model.sv]
`timescale 1ns/1ps
module fpsc_model
  import fpsc_pkg::*;
(
  input  wire fpsc_cmpl_t cmpl,
  input  wire logic [1:0] pc,
  input  wire logic       wre,
  output logic [6:0]      prec,
  output logic [4:0]      expw,
  output logic            rsvd
);

  always_comb begin
    prec = PREC_EXT;
    expw = EXPW_REG;
    rsvd = 1'b0;
    case (cmpl)
      CMPL_SINGLE: begin
        prec = PREC_SGL;
        expw = wre ? EXPW_REG : EXPW_SGL;
      end
      CMPL_DOUBLE: begin
        prec = PREC_DBL;
        expw = wre ? EXPW_REG : EXPW_DBL;
      end
      CMPL_NONE: begin
        expw = wre ? EXPW_REG : EXPW_STK;
        case (pc)
          2'h0: prec = PREC_SGL;
          2'h2: prec = PREC_DBL;
          2'h3: prec = PREC_EXT;
          default: begin
            prec = 7'h00;
            expw = 5'h00;
            rsvd = 1'b1;
          end
        endcase
      end
      CMPL_PARALLEL: begin
        prec = PREC_SGL;
        expw = EXPW_SGL;
      end
      default: begin
        prec = PREC_EXT;
        expw = EXPW_REG;
      end
    endcase
  end

endmodule : fpsc_model

// [core/fpsc_pkg.sv]
package fpsc_pkg;

  // Status register layout
  localparam int TRAP_LSB  = 0;
  localparam int TRAP_W    = 6;
  localparam int SET_BASE  = 6;
  localparam int SET_W     = 13;
  localparam int NUM_SETS  = 4;
  localparam int RSV_LSB   = 58;
  localparam int MAIN_TD   = 12;

  // Exception bit order in traps and flags
  localparam int EX_V = 0;
  localparam int EX_D = 1;
  localparam int EX_Z = 2;
  localparam int EX_O = 3;
  localparam int EX_U = 4;
  localparam int EX_I = 5;

  // Field positions inside one status set
  localparam int FS_FTZ  = 0;
  localparam int FS_WRE  = 1;
  localparam int FS_TD   = 6;
  localparam int FS_FLAG = 7;

  // Bus map (byte addresses)
  localparam logic [3:0] ADDR_LO   = 4'h0;
  localparam logic [3:0] ADDR_HI   = 4'h4;
  localparam logic [3:0] ADDR_LAST = 4'h8;

  // Reset: all traps disabled, double-extended precision, nearest
  localparam logic [5:0]  RST_TRAPS = 6'h3f;
  localparam logic [12:0] RST_SET   = 13'h000c;

  // Register-format encodings
  localparam logic [16:0] EXP_MAX    = 17'h1ffff;
  localparam logic [16:0] EXP_NOT_A_THING_VALUE = 17'h1fffe;
  localparam logic [16:0] EXP_PZ_TOP = 17'h1fffd;
  localparam logic [16:0] EXP_ONE    = 17'h0ffff;
  localparam logic [16:0] EXP_DE_MIN = 17'h0c001;
  localparam logic [16:0] EXP_ZERO   = 17'h00000;
  localparam logic [63:0] SIG_ZERO   = 64'h0000000000000000;
  localparam logic [63:0] SIG_ONE    = 64'h8000000000000000;

  // Computation-model figures
  localparam logic [6:0] PREC_SGL = 7'h18;
  localparam logic [6:0] PREC_DBL = 7'h35;
  localparam logic [6:0] PREC_EXT = 7'h40;
  localparam logic [4:0] EXPW_SGL = 5'h08;
  localparam logic [4:0] EXPW_DBL = 5'h0b;
  localparam logic [4:0] EXPW_STK = 5'h0f;
  localparam logic [4:0] EXPW_REG = 5'h11;

  typedef enum logic [2:0] {
    CMPL_NONE, CMPL_SINGLE, CMPL_DOUBLE, CMPL_PARALLEL, CMPL_FIXED
  } fpsc_cmpl_t;

  typedef struct packed {
    logic [5:0] flags;
    logic       td;
    logic [1:0] rc;
    logic [1:0] pc;
    logic       wre;
    logic       ftz;
  } fpsc_set_t;

  typedef struct packed {
    logic        valid;
    logic [1:0]  sf;
    fpsc_cmpl_t  cmpl;
    logic [5:0]  exc;
    logic        tiny;
    logic        unorm_op;
    logic        nan_op;
    logic        pz_inf;
    logic        spec_fail;
    logic        sign;
    logic [16:0] exp;
    logic [63:0] sig;
  } fpsc_exec_t;

  typedef struct packed {
    logic        valid;
    logic        fault;
    logic [5:0]  cause;
    logic [1:0]  rc;
    logic [6:0]  prec;
    logic [4:0]  expw;
    logic        rsvd;
    logic        sign;
    logic [16:0] exp;
    logic [63:0] sig;
  } fpsc_resp_t;

endpackage : fpsc_pkg

// [core/fpsc_top.sv]
// Decided for this implementation: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
// What this block does
// - four 13-bit sets above six trap bits
// - bits 0-5 disable the six exceptions
// - set fields: ftz, wre, pc, rc, td
// - set bits 7-12 are sticky flags
// - main set td reads zero
// - alternate td disables all six traps
// - faults only from executing instructions
// - flush only with underflow disabled
// - flush sets underflow and inexact flags
// - rounding control picks four directions
// - static completer fixes precision; wre picks the range
// - dynamic precision and range without completer
// - parallel and other fixed models
// - any encoding accepted as operand
// - results use most normalized encoding
// - denormal results use exponent zero
// - never produce pseudo encodings
// - pseudo-zero acts as zero, but times infinity raises no invalid
// - denormal flag only from real arithmetic
// - constant registers zero and one
// - failed speculation writes not-a-thing value
module fpsc_top
  import fpsc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic [31:0]      hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire fpsc_exec_t  exec_in,
  input  wire logic        const_rd,
  input  wire logic        const_sel,
  output fpsc_resp_t       resp_out,
  output logic [63:0]      const_sig,
  output logic [16:0]      const_exp
);

  logic [63:0] fp_status_control;
  logic [63:0] next_fp_status_control;
  logic        wr_pend;
  logic        wr_hi;
  logic [5:0]  last_cause;
  logic [5:0]  next_last_cause;

  // Bus decode
  wire         acc_go   = hsel & hready & htrans[1];
  wire [3:0]   acc_addr = haddr[3:0];
  wire         acc_map  = (haddr[31:4] == 28'h0000000);
  wire         wr_go    = acc_go & hwrite & acc_map
                          & ((acc_addr == ADDR_LO) | (acc_addr == ADDR_HI));
  wire         rd_go    = acc_go & ~hwrite;
  wire         unused_b = ^hsize;

  // Status sets
  fpsc_set_t   sets [NUM_SETS];
  logic [63:0] hw_set;
  logic [5:0]  flag_upd;

  genvar k;
  generate
    for (k = 0; k < NUM_SETS; k++) begin : g_set
      localparam int LSB = SET_BASE + k * SET_W;
      assign sets[k] = fpsc_set_t'(fp_status_control[LSB +: SET_W]);
      assign hw_set[LSB +: SET_W] =
        (exec_in.valid && exec_in.sf == 2'(k))
        ? {flag_upd, 7'h00} : 13'h0000;
    end
  endgenerate
  assign hw_set[TRAP_W-1:0] = 6'h00;
  assign hw_set[63:RSV_LSB] = 6'h00;

  // Selected set for the instruction in flight
  wire fpsc_set_t sel = sets[exec_in.sf];

  wire       td_eff  = (exec_in.sf != 2'h0) & sel.td;
  wire [5:0] dis     = fp_status_control[TRAP_W-1:0] | {6{td_eff}};
  wire [5:0] en      = ~dis;

  // flush only while underflow is disabled
  wire       ftz_eff = sel.ftz & dis[EX_U];
  wire       flush   = exec_in.valid & exec_in.tiny
                       & ftz_eff & ~exec_in.spec_fail;

  // Exception vector as the flags see it
  always_comb begin
    flag_upd = exec_in.exc;
    // denormal flag from real arithmetic only
    flag_upd[EX_D] = exec_in.unorm_op & ~exec_in.nan_op;
    if (exec_in.pz_inf) begin
      flag_upd[EX_V] = 1'b0;
    end
    if (flush) begin
      flag_upd[EX_U] = 1'b1;
      flag_upd[EX_I] = 1'b1;
    end
    if (exec_in.spec_fail) begin
      flag_upd = 6'h00;
    end
  end

  // only enabled exceptions of real work fault
  wire [5:0] fault_vec = exec_in.valid ? (flag_upd & en) : 6'h00;
  wire       fault_now = |fault_vec;

  // Software write merge, then hardware flag sets win
  wire [63:0] wmask = wr_hi ? {32'hffffffff, 32'h00000000}
                            : {32'h00000000, 32'hffffffff};
  wire [63:0] sw_val = wr_pend
                       ? ((fp_status_control & ~wmask) | ({hwdata, hwdata} & wmask))
                       : fp_status_control;
  // main td and top bits held at zero
  wire [63:0] keep_mask = ~((64'h1 << MAIN_TD)
                            | {6'h3f, 58'h0});
  assign next_fp_status_control = (sw_val | hw_set) & keep_mask;

  assign next_last_cause = fault_now ? fault_vec : last_cause;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fp_status_control <= {6'h00, RST_SET, RST_SET, RST_SET,
                            RST_SET & ~(13'h0001 << FS_TD), RST_TRAPS};
      last_cause        <= 6'h00;
    end else begin
      fp_status_control <= next_fp_status_control;
      last_cause        <= next_last_cause;
    end
  end

  // AHB-Lite slave: zero wait, always OKAY
  wire [31:0] rd_word =
    !acc_map                ? 32'h00000000 :
    (acc_addr == ADDR_LO)   ? next_fp_status_control[31:0] :
    (acc_addr == ADDR_HI)   ? next_fp_status_control[63:32] :
    (acc_addr == ADDR_LAST) ? {26'h0000000, next_last_cause} :
                              32'h00000000;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wr_pend   <= 1'b0;
      wr_hi     <= 1'b0;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend   <= wr_go;
      wr_hi     <= acc_addr == ADDR_HI;
      hrdata    <= rd_go ? rd_word : hrdata;
      hreadyout <= 1'b1;
      hresp     <= unused_b & 1'b0;
    end
  end

  // Computation model for the selected set
  logic [6:0] m_prec;
  logic [4:0] m_expw;
  logic       m_rsvd;

  fpsc_model u_model (
    .cmpl (exec_in.cmpl),
    .pc   (sel.pc),
    .wre  (sel.wre),
    .prec (m_prec),
    .expw (m_expw),
    .rsvd (m_rsvd)
  );

  // Result encoding clean-up
  // every operand encoding is accepted
  wire        r_int   = exec_in.sig[63];
  wire        r_sig0  = exec_in.sig == SIG_ZERO;
  wire        r_pzero = (exec_in.exp != EXP_ZERO)
                        & (exec_in.exp <= EXP_PZ_TOP) & r_sig0;
  wire        r_pden  = (exec_in.exp == EXP_ZERO) & r_int;
  wire        r_dden  = (exec_in.exp == EXP_DE_MIN) & ~r_int & ~r_sig0;
  wire        r_pnan  = (exec_in.exp == EXP_MAX) & ~r_int;

  logic        next_sign;
  logic [16:0] next_exp;
  logic [63:0] next_sig;
  always_comb begin
    next_sign = exec_in.sign;
    next_exp  = exec_in.exp;
    next_sig  = exec_in.sig;
    if (exec_in.spec_fail) begin
      next_sign = 1'b0;
      next_exp  = EXP_NOT_A_THING_VALUE;
      next_sig  = SIG_ZERO;
    end else if (flush) begin
      next_exp  = EXP_ZERO;
      next_sig  = SIG_ZERO;
    end else if (r_pzero) begin
      next_exp  = EXP_ZERO;
    end else if (r_pden) begin
      next_exp  = EXP_DE_MIN;
    end else if (r_dden) begin
      next_exp  = EXP_ZERO;
    end else if (r_pnan) begin
      next_sig  = exec_in.sig | SIG_ONE;
    end
  end

  // Response holds rounding and model of the instruction's selected set
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      resp_out <= '0;
    end else begin
      resp_out.valid <= exec_in.valid;
      resp_out.fault <= fault_now;
      resp_out.cause <= fault_vec;
      resp_out.rc    <= sel.rc;
      resp_out.prec  <= m_prec;
      resp_out.expw  <= m_expw;
      resp_out.rsvd  <= exec_in.valid & m_rsvd;
      resp_out.sign  <= next_sign;
      resp_out.exp   <= next_exp;
      resp_out.sig   <= next_sig;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      const_exp <= EXP_ZERO;
      const_sig <= SIG_ZERO;
    end else if (const_rd) begin
      const_exp <= const_sel ? EXP_ONE : EXP_ZERO;
      const_sig <= const_sel ? SIG_ONE : SIG_ZERO;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  wire [63:0] flag_mask = {6'h00, {4{6'h3f, 7'h00}}, 6'h00};
  wire [63:0] ui_mask   = 64'h3 << (SET_BASE + exec_in.sf * SET_W
                                    + FS_FLAG + EX_U);

  property p_rsv_zero;
    fp_status_control[63:RSV_LSB] == 6'h00;
  endproperty
  a_rsv_zero: assert property (p_rsv_zero)
    else $error("reserved top bits not zero");

  property p_main_td;
    wr_pend |=> fp_status_control[MAIN_TD] == 1'b0;
  endproperty
  a_main_td: assert property (p_main_td)
    else $error("main set td not zero");

  property p_sticky;
    !wr_pend |=> ((fp_status_control & flag_mask)
                  & $past(fp_status_control)) ==
                 ($past(fp_status_control) & flag_mask);
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("flag cleared without a write");

  property p_no_sw_fault;
    !exec_in.valid |=> !resp_out.fault;
  endproperty
  a_no_sw_fault: assert property (p_no_sw_fault)
    else $error("fault without an instruction");

  property p_td_override;
    exec_in.valid && exec_in.sf != 2'h0 && sel.td |=> !resp_out.fault;
  endproperty
  a_td_override: assert property (p_td_override)
    else $error("override set but fault raised");

  property p_flush_flags;
    flush |=> ((fp_status_control & $past(ui_mask)) == $past(ui_mask))
              && resp_out.exp == EXP_ZERO && resp_out.sig == SIG_ZERO;
  endproperty
  a_flush_flags: assert property (p_flush_flags)
    else $error("flush missed flags or zero");

  property p_not_a_thing_value;
    exec_in.valid && exec_in.spec_fail |=> !resp_out.sign
      && resp_out.exp == EXP_NOT_A_THING_VALUE && resp_out.sig == SIG_ZERO
      && !resp_out.fault;
  endproperty
  a_not_a_thing_value: assert property (p_not_a_thing_value)
    else $error("bad not-a-thing result");

  property p_no_pzero;
    resp_out.valid && resp_out.exp != EXP_ZERO
      && resp_out.exp <= EXP_PZ_TOP |-> resp_out.sig != SIG_ZERO;
  endproperty
  a_no_pzero: assert property (p_no_pzero)
    else $error("pseudo-zero produced");

  property p_rc;
    exec_in.valid |=> resp_out.rc == $past(sel.rc);
  endproperty
  a_rc: assert property (p_rc)
    else $error("rounding control not passed");

  property p_ufl_prio;
    exec_in.valid && exec_in.tiny && !dis[EX_U] && !exec_in.spec_fail
      |=> !(resp_out.exp == EXP_ZERO && resp_out.sig == SIG_ZERO
            && $past(exec_in.sig) != SIG_ZERO
            && $past(exec_in.exp) != EXP_ZERO);
  endproperty
  a_ufl_prio: assert property (p_ufl_prio)
    else $error("flushed while underflow enabled");

  property p_const;
    const_rd |=> const_sig == ($past(const_sel) ? SIG_ONE : SIG_ZERO)
                 && const_exp == ($past(const_sel) ? EXP_ONE : EXP_ZERO);
  endproperty
  a_const: assert property (p_const)
    else $error("constant register value wrong");

  c_flush: cover property (flush ##1 resp_out.valid);
  c_fault: cover property (exec_in.valid ##1 resp_out.fault);
  c_write: cover property (wr_go ##1 wr_pend);
  c_spec:  cover property (exec_in.valid && exec_in.spec_fail);

endmodule : fpsc_top
